/* core/rlre_pkg.sv */
// Package for the rotate and literal-return execution block
// Notes on behaviour
// - Literal return loads W with 8-bit literal
// - Literal return pops stack into program counter
// - Literal return: one word, two cycles, flags kept
// - Rotate left: carry into bit0, bit7 out
// - Destination bit 0 writes W, 1 writes register
// - Rotate right: carry into bit7, bit0 out
package rlre_pkg;
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 7;
    localparam int PC_W      = 11;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic       C_RESET = 1'b0;
    localparam logic       DEST_W  = 1'b0;
    localparam logic       DEST_F  = 1'b1;
    // Cycles of the literal return
    localparam int RET_CYCLES = 2;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_RETURN_WITH_LITERAL,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY
    } rlre_op_t;

    // One decoded instruction from the decoder
    typedef struct packed {
        rlre_op_t            op;
        logic [DATA_W-1:0]   literal;
        logic [ADDR_W-1:0]   fileAddr;
        logic                dest;
    } rlre_instr_t;

    // One register file write
    typedef struct packed {
        logic                en;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } rlre_fwrite_t;
endpackage

/* core/rlre_exec.sv */
// Execution of literal return and rotate-through-carry instructions
`timescale 1ns/10ps
`default_nettype none
module rlre_exec
    import rlre_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // Decoder side
    input  wire rlre_instr_t         instr,
    input  wire logic                instrValid,
    output logic                     busy,
    // Register file read of the addressed location
    input  wire logic [DATA_W-1:0]   fileRdData,
    output logic [ADDR_W-1:0]        fileRdAddr,
    // Register file write
    output rlre_fwrite_t             fileWr,
    // Working register and carry
    output logic [DATA_W-1:0]        wReg,
    output logic                     carry,
    // Return-address stack and program counter
    input  wire logic [PC_W-1:0]     stackTop,
    output logic                     stackPop,
    output logic                     pcLoad,
    output logic [PC_W-1:0]          pcValue
);
    typedef enum logic {ST_EXEC, ST_FLUSH} rlre_state_t;

    rlre_state_t       state_q;
    logic [DATA_W-1:0] w_q;
    logic              c_q;
    logic              busy_q;
    logic              pop_q;
    logic              pcLoad_q;
    logic [PC_W-1:0]   pc_q;
    rlre_fwrite_t      fw_q;

    // Rotate through carry: returns {carry out, result}
    function automatic logic [DATA_W:0] rotC(
        input logic [DATA_W-1:0] v,
        input logic              c,
        input logic              left
    );
        if (left) begin
            rotC = {v[DATA_W-1], v[DATA_W-2:0], c};
        end else begin
            rotC = {v[0], c, v[DATA_W-1:1]};
        end
    endfunction

    logic              take;
    logic              isRot;
    logic [DATA_W:0]   rot;
    assign take  = instrValid && state_q == ST_EXEC;
    assign isRot = instr.op == OP_ROTATE_LEFT_CARRY
                || instr.op == OP_ROTATE_RIGHT_CARRY;
    assign rot   = rotC(fileRdData, c_q,
                        instr.op == OP_ROTATE_LEFT_CARRY);
    assign fileRdAddr = instr.fileAddr; // Address field is 7 bits

    // Sequencer: literal return holds a second cycle for the fetch flush
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_EXEC;
            busy_q  <= 1'b0;
        end else begin
            case (state_q)
                ST_EXEC: begin
                    if (take && instr.op == OP_RETURN_WITH_LITERAL) begin
                        state_q <= ST_FLUSH;
                        busy_q  <= 1'b1;
                    end
                end
                ST_FLUSH: begin
                    state_q <= ST_EXEC;
                    busy_q  <= 1'b0;
                end
                default: begin
                    state_q <= ST_EXEC;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // Working register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            w_q <= W_RESET;
        end else if (take) begin
            if (instr.op == OP_RETURN_WITH_LITERAL) begin
                w_q <= instr.literal; // Any 0..255 value
            end else if (isRot && instr.dest == DEST_W) begin
                w_q <= rot[DATA_W-1:0];
            end
        end
    end

    // Carry changes only on rotates; literal return leaves it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            c_q <= C_RESET;
        end else if (take && isRot) begin
            c_q <= rot[DATA_W];
        end
    end

    // Register file write-back, one cycle pulse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fw_q <= '0;
        end else begin
            fw_q.en   <= take && isRot && instr.dest == DEST_F;
            fw_q.addr <= instr.fileAddr;
            fw_q.data <= rot[DATA_W-1:0];
        end
    end

    // Stack pop and PC load in the flush cycle of the literal return
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pop_q    <= 1'b0;
            pcLoad_q <= 1'b0;
            pc_q     <= '0;
        end else begin
            pop_q    <= take && instr.op == OP_RETURN_WITH_LITERAL;
            pcLoad_q <= take && instr.op == OP_RETURN_WITH_LITERAL;
            if (take && instr.op == OP_RETURN_WITH_LITERAL) begin
                pc_q <= stackTop;
            end
        end
    end

    assign busy     = busy_q;
    assign wReg     = w_q;
    assign carry    = c_q;
    assign fileWr   = fw_q;
    assign stackPop = pop_q;
    assign pcLoad   = pcLoad_q;
    assign pcValue  = pc_q;

    // Return length, taking edge included, as a count for the checks
    localparam int RET_SPAN = RET_CYCLES;

    // Literal return: busy through the flush cycle, PC loaded at once
    ret_two_cycle_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_RETURN_WITH_LITERAL
        |=> busy && pcLoad ##1 !busy)
        else $error("literal return not two cycles");
    // Nothing of the return still active once its span has run out
    ret_cycle_span_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_RETURN_WITH_LITERAL
        |-> ##RET_SPAN !busy && !pcLoad && !stackPop)
        else $error("literal return span wrong");
    // W gets the literal whatever its value
    ret_loads_w_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_RETURN_WITH_LITERAL
        |=> wReg == $past(instr.literal))
        else $error("W not loaded with literal");
    // Pop comes together with the PC value set to the saved return address
    ret_pops_stack_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_RETURN_WITH_LITERAL
        |=> stackPop && pcValue == $past(stackTop))
        else $error("PC not loaded from stack top");
    // Only rotates may touch the carry
    ret_keeps_carry_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && !isRot |=> $stable(carry))
        else $error("carry changed outside rotate");
    // Flush cycle refuses the decoder: no write, no pop, W and carry kept
    busy_ignores_instr_a: assert property (
        @(posedge clk) disable iff (!resetn)
        busy |=> !fileWr.en && !stackPop && !pcLoad
            && $stable(wReg) && $stable(carry))
        else $error("instruction taken during flush");
    // Rotate left into W, old carry in at bit zero
    rot_left_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_ROTATE_LEFT_CARRY && instr.dest == DEST_W
        |=> wReg == {$past(fileRdData[6:0]), $past(carry)}
            && carry == $past(fileRdData[7]))
        else $error("rotate left wrong");
    // Rotate right into W, old carry in at the top bit
    rot_right_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_ROTATE_RIGHT_CARRY && instr.dest == DEST_W
        |=> wReg == {$past(carry), $past(fileRdData[7:1])}
            && carry == $past(fileRdData[0]))
        else $error("rotate right wrong");
    // Rotate to W leaves the register file alone
    rot_dest_w_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && isRot && instr.dest == DEST_W |=> !fileWr.en)
        else $error("rotate to W wrote the register");
    // Rotate back to the register leaves W alone
    rot_dest_file_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && isRot && instr.dest == DEST_F
        |=> fileWr.en && fileWr.addr == $past(instr.fileAddr)
            && $stable(wReg))
        else $error("rotate to file wrong");
    // Written-back value of a rotate left, with the carry it leaves
    rol_file_data_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_ROTATE_LEFT_CARRY && instr.dest == DEST_F
        |=> fileWr.data == {$past(fileRdData[6:0]), $past(carry)}
            && carry == $past(fileRdData[7]))
        else $error("rotate left to register wrong");
    // Written-back value of a rotate right, with the carry it leaves
    ror_file_data_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && instr.op == OP_ROTATE_RIGHT_CARRY && instr.dest == DEST_F
        |=> fileWr.data == {$past(carry), $past(fileRdData[7:1])}
            && carry == $past(fileRdData[0]))
        else $error("rotate right to register wrong");
    // A rotate never holds the decoder off
    rot_one_cycle_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && isRot |=> !busy && !stackPop)
        else $error("rotate not single cycle");
    // Reset state seen at the edge after any reset edge
    reset_values_a: assert property (
        @(posedge clk)
        !resetn |=> wReg == W_RESET && carry == C_RESET && !busy
            && !fileWr.en && !stackPop && !pcLoad && pcValue == '0)
        else $error("state not cleared by reset");
endmodule // rlre_exec
`default_nettype wire

/* dv/tb_rlre_exec.sv */
// Self-checking bench for the rotate and literal-return execution block
`timescale 1ns/10ps
`default_nettype none
module tb_rlre_exec
    import rlre_pkg::*;
;
    typedef struct packed {
        logic [7:0]  w;
        logic        c;
        logic        en;
        logic [6:0]  a;
        logic [7:0]  d;
        logic        pop;
        logic        pcl;
        logic [10:0] pcv;
        logic        busy;
    } rlre_note_t;

    logic               clk = 1'b0;
    logic               resetn = 1'b0;
    rlre_instr_t        instr = '0;
    logic               instrValid = 1'b0;
    logic               busy;
    logic [DATA_W-1:0]  fileRdData = 8'h00;
    logic [ADDR_W-1:0]  fileRdAddr;
    rlre_fwrite_t       fileWr;
    logic [DATA_W-1:0]  wReg;
    logic               carry;
    logic [PC_W-1:0]    stackTop = 11'h000;
    logic               stackPop;
    logic               pcLoad;
    logic [PC_W-1:0]    pcValue;
    rlre_note_t         notes[$];
    rlre_note_t         seenNote;
    int                 errors = 0;
    int                 samples_checked = 0;
    int                 seed = 32;
    logic [31:0]        r1;
    logic [31:0]        r2;
    // Reference state, advanced as instructions are taken
    logic [7:0]         wM = 8'h00;
    logic               cM = 1'b0;
    logic [10:0]        pcM = 11'h000;
    logic               bsyM = 1'b0;

    rlre_exec uut (.clk(clk), .resetn(resetn), .instr(instr),
        .instrValid(instrValid), .busy(busy), .fileRdData(fileRdData),
        .fileRdAddr(fileRdAddr), .fileWr(fileWr), .wReg(wReg),
        .carry(carry), .stackTop(stackTop), .stackPop(stackPop),
        .pcLoad(pcLoad), .pcValue(pcValue));

    // 250 MHz clock
    always #2 clk = ~clk;

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One cycle of stimulus; the note is queued at the taking edge
    task automatic step(input rlre_op_t op, input logic [7:0] k,
        input logic [6:0] a, input logic d, input logic [7:0] f,
        input logic [10:0] top, input logic v);
        rlre_note_t n;
        logic [7:0] r;
        instr <= {op, k, a, d};
        instrValid <= v;
        fileRdData <= f;
        stackTop <= top;
        n = '0;
        // Second cycle of a literal return swallows this one
        if (v && !bsyM && op == OP_RETURN_WITH_LITERAL) begin
            wM = k;
            pcM = top;
            n.pop = 1'b1;
            n.pcl = 1'b1;
            n.busy = 1'b1;
        end else if (v && !bsyM && op != OP_NONE) begin
            r = (op == OP_ROTATE_LEFT_CARRY) ? {f[6:0], cM} : {cM, f[7:1]};
            cM = (op == OP_ROTATE_LEFT_CARRY) ? f[7] : f[0];
            if (d == DEST_W) wM = r;
            else begin
                n.en = 1'b1;
                n.a = a;
                n.d = r;
            end
        end
        bsyM = n.busy;
        n.w = wM;
        n.c = cM;
        n.pcv = pcM;
        @(posedge clk);
        notes.push_back(n);
    endtask

    // Results settle after the edge; compare at the falling edge
    always @(negedge clk) begin
        if (notes.size() > 0) begin
            seenNote = notes.pop_front();
            check("wReg", 16'(wReg), 16'(seenNote.w));
            check("carry", 16'(carry), 16'(seenNote.c));
            check("fileWr.en", 16'(fileWr.en), 16'(seenNote.en));
            if (seenNote.en) begin
                check("fileWr.addr", 16'(fileWr.addr), 16'(seenNote.a));
                check("fileWr.data", 16'(fileWr.data), 16'(seenNote.d));
            end
            check("stackPop", 16'(stackPop), 16'(seenNote.pop));
            check("pcLoad", 16'(pcLoad), 16'(seenNote.pcl));
            check("pcValue", 16'(pcValue), 16'(seenNote.pcv));
            check("busy", 16'(busy), 16'(seenNote.busy));
            check("fileRdAddr", 16'(fileRdAddr),
                  16'(instr.fileAddr));
        end
    end

    task automatic wrap_up();
        $display("Checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles of the run
    initial begin
        #8000;
        errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        // Worked examples, then literal returns, the first with a rotate and the second with a valid OP_NONE offered and swallowed in its flush cycle
        step(OP_ROTATE_LEFT_CARRY, 8'h00, 7'h7F, DEST_W, 8'hE6, 11'h000, 1'b1);
        step(OP_ROTATE_RIGHT_CARRY, 8'h00, 7'h00, DEST_F, 8'h01, 11'h000, 1'b1);
        step(OP_RETURN_WITH_LITERAL, 8'hFF, 7'h00, DEST_W, 8'h00, 11'h7FF, 1'b1);
        step(OP_ROTATE_LEFT_CARRY, 8'h00, 7'h11, DEST_F, 8'hAA, 11'h000, 1'b1);
        step(OP_RETURN_WITH_LITERAL, 8'h00, 7'h00, DEST_W, 8'h00, 11'h001, 1'b1);
        step(OP_NONE, 8'h00, 7'h00, DEST_W, 8'h00, 11'h000, 1'b1);
        step(OP_NONE, 8'h00, 7'h00, DEST_W, 8'h00, 11'h000, 1'b0);
        $display("Directed test done");
        // Random mix of all operations, valid and idle cycles
        for (int i = 0; i < 400; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            step(rlre_op_t'(r1[1:0]), r1[9:2], r1[16:10], r1[17], r2[7:0],
                 r2[18:8], r2[19] | r2[20]);
        end
        instrValid <= 1'b0;
        $display("Random test done");
        @(negedge clk);
        @(posedge clk);
        wrap_up();
    end
endmodule // tb_rlre_exec
`default_nettype wire
